// ==== adcr_consts.svh ====
// Offsets, reset values, field positions and timing counts of the output rate config block
`ifndef ADCR_CONSTS_SVH
`define ADCR_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADCR_OFS_GEN_CTRL 7'h01
`define ADCR_OFS_RATE 7'h02
`define ADCR_OFS_TIMING 7'h04
`define ADCR_OFS_RANDPOL 7'h07
`define ADCR_OFS_CAL_DELAY 7'h1E

// ****************************************
// Reset values
// ****************************************
`define ADCR_RST_GEN_CTRL 8'h00
`define ADCR_RST_RATE 8'h0F
`define ADCR_RST_TIMING 8'h9F
`define ADCR_RST_RANDPOL 8'h62
`define ADCR_RST_CAL_DELAY 8'h80

// ****************************************
// Field positions
// ****************************************
`define ADCR_BIT_IND_RATE 0
`define ADCR_BIT_SDO_EDGE 7
`define ADCR_BIT_WORD_CLK_INV 7
`define ADCR_BIT_CAL_EN 6
`define ADCR_BIT_RAND_EN 0
`define ADCR_DRATE_HI 7
`define ADCR_DRATE_LO 4
`define ADCR_CRATE_HI 3
`define ADCR_CRATE_LO 0

// ****************************************
// Rate codes
// ****************************************
`define ADCR_CODE_FULL 4'h0
`define ADCR_CODE_ZERO_MIN 4'hD
`define ADCR_CODE_NOCLK_MIN 4'hA
`define ADCR_CODE_NOCLK_MAX 4'hE
`define ADCR_CODE_CLK_FULL 4'hF
`define ADCR_CODE_DIV_TOP 4'h8
`define ADCR_SHIFT_MAX 4'h9
`define ADCR_SHIFT_ONE 4'h1

// ****************************************
// Serial frame
// ****************************************
`define ADCR_SPI_HDR_LAST 5'h07
`define ADCR_SPI_DATA_FIRST 5'h08
`define ADCR_SPI_FRAME_LAST 5'h0F
`define ADCR_SPI_FRAME_BITS 5'h10

// ****************************************
// Timing
// ****************************************
`define ADCR_CLK_PERIOD_NS 8
`define ADCR_CAL_STEP_NS 128
`define ADCR_CAL_STEP_CYC ((`ADCR_CAL_STEP_NS + `ADCR_CLK_PERIOD_NS - 1) / `ADCR_CLK_PERIOD_NS)

`endif

// ==== adcr_pkg.sv ====
// Types shared by the output rate config block
package adcr_pkg;
	typedef enum logic {
		CAL_IDLE,
		CAL_WAIT
	} adcr_cal_state_t;
	typedef logic [3:0] adcr_shift_t;
endpackage : adcr_pkg

// ==== adcr_reg_if.sv ====
// Register access carrier between serial slave and register bank
`timescale 1ns/1ps
interface adcr_reg_if;
	logic [6:0] addr;
	logic [7:0] wrData;
	logic wrEn;
	logic [7:0] rdData;
	logic sdoFallEdge;
	modport spi (output addr, output wrData, output wrEn, input rdData, input sdoFallEdge);
	modport regs (input addr, input wrData, input wrEn, output rdData, output sdoFallEdge);
endinterface : adcr_reg_if

// ==== adcr_spi_slave.sv ====
// Serial register access slave with selectable read-data launch edge
`timescale 1ns/1ps
`include "adcr_consts.svh"
module adcr_spi_slave (
	input wire logic clock,
	input wire logic rst,
	input wire logic spiSclk,
	input wire logic spiCsN,
	input wire logic spiSdi,
	output logic spiSdo,
	output logic spiSdoOe,
	adcr_reg_if.spi bus
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] syncA_ff;
	logic [2:0] syncB_ff;
	logic sclkD_ff;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			// Idle pin levels, so no false serial clock edge follows reset
			syncA_ff <= 3'h4;
			syncB_ff <= 3'h4;
			sclkD_ff <= 1'b0;
		end else begin
			syncA_ff <= {spiCsN, spiSclk, spiSdi};
			syncB_ff <= syncA_ff;
			sclkD_ff <= syncB_ff[1];
		end
	end

	logic csActive;
	logic riseDet;
	logic fallDet;
	logic sdiBit;
	assign csActive = ~syncB_ff[2];
	assign riseDet = syncB_ff[1] & ~sclkD_ff;
	assign fallDet = ~syncB_ff[1] & sclkD_ff;
	assign sdiBit = syncB_ff[0];

	// ****************************************
	// Frame engine
	// ****************************************
	logic [4:0] bitCnt_ff, nxt_bitCnt;
	logic [6:0] shift_ff, nxt_shift;
	logic isRead_ff, nxt_isRead;
	logic [6:0] addr_ff, nxt_addr;
	logic loadPend_ff, nxt_loadPend;
	logic sdoBit_ff, nxt_sdoBit;
	logic [7:0] sdoShift_ff, nxt_sdoShift;
	logic wrEn_ff, nxt_wrEn;
	logic [7:0] wrData_ff, nxt_wrData;
	logic present;

	always_comb begin
		nxt_bitCnt = bitCnt_ff;
		nxt_shift = shift_ff;
		nxt_isRead = isRead_ff;
		nxt_addr = addr_ff;
		nxt_loadPend = 1'b0;
		nxt_sdoBit = sdoBit_ff;
		nxt_sdoShift = sdoShift_ff;
		nxt_wrEn = 1'b0;
		nxt_wrData = wrData_ff;
		present = 1'b0;
		if (!csActive) begin
			nxt_bitCnt = 5'h00;
			nxt_isRead = 1'b0;
		end else if (riseDet) begin
			nxt_shift = {shift_ff[5:0], sdiBit};
			nxt_bitCnt = bitCnt_ff + 5'h01;
			if (bitCnt_ff == `ADCR_SPI_HDR_LAST) begin
				nxt_isRead = shift_ff[6];
				nxt_addr = {shift_ff[5:0], sdiBit};
				nxt_loadPend = shift_ff[6];
			end
			if (bitCnt_ff == `ADCR_SPI_FRAME_LAST && !isRead_ff) begin
				nxt_wrEn = 1'b1;
				nxt_wrData = {shift_ff[6:0], sdiBit};
			end
			present = !bus.sdoFallEdge && isRead_ff && bitCnt_ff >= `ADCR_SPI_DATA_FIRST
				&& bitCnt_ff < `ADCR_SPI_FRAME_LAST;
		end else if (fallDet) begin
			present = bus.sdoFallEdge && isRead_ff && bitCnt_ff >= `ADCR_SPI_DATA_FIRST
				&& bitCnt_ff < `ADCR_SPI_FRAME_BITS;
		end
		if (loadPend_ff) begin
			nxt_sdoShift = bus.rdData;
			if (!bus.sdoFallEdge) begin
				nxt_sdoBit = bus.rdData[7];
				nxt_sdoShift = {bus.rdData[6:0], 1'b0};
			end
		end else if (present) begin
			nxt_sdoBit = sdoShift_ff[7];
			nxt_sdoShift = {sdoShift_ff[6:0], 1'b0};
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bitCnt_ff <= 5'h00;
			shift_ff <= 7'h00;
			isRead_ff <= 1'b0;
			addr_ff <= 7'h00;
			loadPend_ff <= 1'b0;
			sdoBit_ff <= 1'b0;
			sdoShift_ff <= 8'h00;
			wrEn_ff <= 1'b0;
			wrData_ff <= 8'h00;
		end else begin
			bitCnt_ff <= nxt_bitCnt;
			shift_ff <= nxt_shift;
			isRead_ff <= nxt_isRead;
			addr_ff <= nxt_addr;
			loadPend_ff <= nxt_loadPend;
			sdoBit_ff <= nxt_sdoBit;
			sdoShift_ff <= nxt_sdoShift;
			wrEn_ff <= nxt_wrEn;
			wrData_ff <= nxt_wrData;
		end
	end

	assign bus.addr = addr_ff;
	assign bus.wrEn = wrEn_ff;
	assign bus.wrData = wrData_ff;
	assign spiSdo = sdoBit_ff;
	assign spiSdoOe = csActive & isRead_ff & (bitCnt_ff >= `ADCR_SPI_DATA_FIRST);

	// ****************************************
	// Checks
	// ****************************************
	sdo_edge_a: assert property (@(posedge clock) disable iff (rst)
		$changed(sdoBit_ff) && !$past(loadPend_ff)
		|-> $past(bus.sdoFallEdge ? fallDet : riseDet))
		else $error("serial read data moved on the wrong edge");
endmodule : adcr_spi_slave

// ==== adcr_output_rate_config.sv ====
// Output rate, word clock, randomizer and calibration delay register bank
`timescale 1ns/1ps
`include "adcr_consts.svh"
module adcr_output_rate_config #(
	parameter int DATA_W = 16,
	parameter int CAL_STEP_CYC = `ADCR_CAL_STEP_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic spiSclk,
	input wire logic spiCsN,
	input wire logic spiSdi,
	output logic spiSdo,
	output logic spiSdoOe,
	input wire logic [DATA_W-1:0] adcData,
	input wire logic adcValid,
	input wire logic calRequest,
	output logic [DATA_W-1:0] outData,
	output logic outValid,
	output logic dataClockOut,
	output logic wordClockOut,
	output logic calStart
);
	if (DATA_W < 2 || CAL_STEP_CYC < 1) begin : paramCheck
		$error("adcr_output_rate_config: unsupported parameters");
	end

	// ****************************************
	// Register access
	// ****************************************
	adcr_reg_if regBus ();
	adcr_spi_slave adcr_spi_slave_inst (
		.clock(clock),
		.rst(rst),
		.spiSclk(spiSclk),
		.spiCsN(spiCsN),
		.spiSdi(spiSdi),
		.spiSdo(spiSdo),
		.spiSdoOe(spiSdoOe),
		.bus(regBus.spi)
	);

	logic [7:0] genCtrl_ff, nxt_genCtrl;
	logic [7:0] rateCtrl_ff, nxt_rateCtrl;
	logic [7:0] timing_ff, nxt_timing;
	logic [7:0] randPol_ff, nxt_randPol;
	logic [7:0] calDelay_ff, nxt_calDelay;

	always_comb begin
		nxt_genCtrl = genCtrl_ff;
		nxt_rateCtrl = rateCtrl_ff;
		nxt_timing = timing_ff;
		nxt_randPol = randPol_ff;
		nxt_calDelay = calDelay_ff;
		if (regBus.wrEn) begin
			case (regBus.addr)
				`ADCR_OFS_GEN_CTRL: nxt_genCtrl = regBus.wrData & 8'h01;
				`ADCR_OFS_RATE: nxt_rateCtrl = regBus.wrData;
				`ADCR_OFS_TIMING: nxt_timing = regBus.wrData;
				`ADCR_OFS_RANDPOL: nxt_randPol = regBus.wrData;
				`ADCR_OFS_CAL_DELAY: nxt_calDelay = regBus.wrData;
				default: nxt_genCtrl = genCtrl_ff;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			genCtrl_ff <= `ADCR_RST_GEN_CTRL;
			rateCtrl_ff <= `ADCR_RST_RATE;
			timing_ff <= `ADCR_RST_TIMING;
			randPol_ff <= `ADCR_RST_RANDPOL;
			calDelay_ff <= `ADCR_RST_CAL_DELAY;
		end else begin
			genCtrl_ff <= nxt_genCtrl;
			rateCtrl_ff <= nxt_rateCtrl;
			timing_ff <= nxt_timing;
			randPol_ff <= nxt_randPol;
			calDelay_ff <= nxt_calDelay;
		end
	end

	always_comb begin
		case (regBus.addr)
			`ADCR_OFS_GEN_CTRL: regBus.rdData = genCtrl_ff;
			`ADCR_OFS_RATE: regBus.rdData = rateCtrl_ff;
			`ADCR_OFS_TIMING: regBus.rdData = timing_ff;
			`ADCR_OFS_RANDPOL: regBus.rdData = randPol_ff;
			`ADCR_OFS_CAL_DELAY: regBus.rdData = calDelay_ff;
			default: regBus.rdData = 8'h00;
		endcase
	end
	assign regBus.sdoFallEdge = timing_ff[`ADCR_BIT_SDO_EDGE];

	// ****************************************
	// Output formatter
	// ****************************************
	// divide by power of two
	function automatic adcr_pkg::adcr_shift_t rateShift(input logic [3:0] code);
		if (code == `ADCR_CODE_FULL || code >= `ADCR_CODE_NOCLK_MIN) begin
			return 4'h0;
		end else if (code >= `ADCR_CODE_DIV_TOP) begin
			return `ADCR_SHIFT_MAX;
		end
		return code + `ADCR_SHIFT_ONE;
	endfunction : rateShift

	function automatic logic [8:0] shiftMask(input adcr_pkg::adcr_shift_t s);
		return (9'h001 << s) - 9'h001;
	endfunction : shiftMask

	logic [3:0] dataCode;
	logic [3:0] clkCode;
	logic indRate;
	assign dataCode = rateCtrl_ff[`ADCR_DRATE_HI:`ADCR_DRATE_LO];
	assign clkCode = rateCtrl_ff[`ADCR_CRATE_HI:`ADCR_CRATE_LO];
	assign indRate = genCtrl_ff[`ADCR_BIT_IND_RATE];

	adcr_pkg::adcr_shift_t actDataShift_ff, nxt_actDataShift;
	adcr_pkg::adcr_shift_t actClkShift_ff, nxt_actClkShift;
	logic actZero_ff, nxt_actZero;
	logic actNoClk_ff, nxt_actNoClk;
	logic [8:0] wordCnt_ff, nxt_wordCnt;
	logic [8:0] clkCnt_ff, nxt_clkCnt;
	logic [DATA_W-1:0] outData_ff, nxt_outData;
	logic outValid_ff, nxt_outValid;
	logic dataClk_ff, nxt_dataClk;
	logic wordTog_ff, nxt_wordTog;
	logic wordClk_ff, nxt_wordClk;
	logic boundary;
	logic [DATA_W-1:0] scrambled;

	assign boundary = wordCnt_ff == shiftMask(actDataShift_ff);
	assign scrambled = randPol_ff[`ADCR_BIT_RAND_EN]
		? adcData ^ {{(DATA_W-1){adcData[0]}}, 1'b0} : adcData;

	always_comb begin
		nxt_actDataShift = actDataShift_ff;
		nxt_actClkShift = actClkShift_ff;
		nxt_actZero = actZero_ff;
		nxt_actNoClk = actNoClk_ff;
		nxt_wordCnt = wordCnt_ff;
		nxt_clkCnt = clkCnt_ff;
		nxt_outData = outData_ff;
		nxt_outValid = 1'b0;
		nxt_dataClk = actNoClk_ff ? 1'b0 : dataClk_ff;
		nxt_wordTog = wordTog_ff;
		if (adcValid && boundary) begin
			nxt_outData = actZero_ff ? '0 : scrambled;
			nxt_outValid = 1'b1;
			nxt_wordTog = ~wordTog_ff;
			nxt_wordCnt = 9'h000;
			nxt_actDataShift = rateShift(dataCode);
			nxt_actZero = dataCode >= `ADCR_CODE_ZERO_MIN;
			if (indRate) begin
				nxt_actClkShift = clkCode == `ADCR_CODE_CLK_FULL ? 4'h0 : rateShift(clkCode);
				nxt_actNoClk = clkCode >= `ADCR_CODE_NOCLK_MIN
					&& clkCode <= `ADCR_CODE_NOCLK_MAX;
			end else begin
				nxt_actClkShift = rateShift(dataCode);
				nxt_actNoClk = 1'b0;
			end
		end else if (adcValid) begin
			nxt_wordCnt = wordCnt_ff + 9'h001;
		end
		// clock divider on every valid word while the clock runs, realigned to data when not independent
		if (adcValid && !actNoClk_ff) begin
			if (clkCnt_ff >= shiftMask(actClkShift_ff) || (boundary && !indRate)) begin
				nxt_clkCnt = 9'h000;
				nxt_dataClk = ~dataClk_ff;
			end else begin
				nxt_clkCnt = clkCnt_ff + 9'h001;
			end
		end
		nxt_wordClk = nxt_wordTog ^ randPol_ff[`ADCR_BIT_WORD_CLK_INV];
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			actDataShift_ff <= 4'h0;
			actClkShift_ff <= 4'h0;
			actZero_ff <= 1'b0;
			actNoClk_ff <= 1'b0;
			wordCnt_ff <= 9'h000;
			clkCnt_ff <= 9'h000;
			outData_ff <= '0;
			outValid_ff <= 1'b0;
			dataClk_ff <= 1'b0;
			wordTog_ff <= 1'b0;
			wordClk_ff <= 1'b0;
		end else begin
			actDataShift_ff <= nxt_actDataShift;
			actClkShift_ff <= nxt_actClkShift;
			actZero_ff <= nxt_actZero;
			actNoClk_ff <= nxt_actNoClk;
			wordCnt_ff <= nxt_wordCnt;
			clkCnt_ff <= nxt_clkCnt;
			outData_ff <= nxt_outData;
			outValid_ff <= nxt_outValid;
			dataClk_ff <= nxt_dataClk;
			wordTog_ff <= nxt_wordTog;
			wordClk_ff <= nxt_wordClk;
		end
	end

	assign outData = outData_ff;
	assign outValid = outValid_ff;
	assign dataClockOut = dataClk_ff;
	assign wordClockOut = wordClk_ff;

	// ****************************************
	// Calibration start delay
	// ****************************************
	localparam int STEP_W = $clog2(CAL_STEP_CYC + 1);
	adcr_pkg::adcr_cal_state_t calState_ff, nxt_calState;
	logic [7:0] calCnt_ff, nxt_calCnt;
	logic [STEP_W-1:0] stepCnt_ff, nxt_stepCnt;
	logic calStart_ff, nxt_calStart;
	logic stepTick;
	assign stepTick = stepCnt_ff == STEP_W'(CAL_STEP_CYC - 1);

	always_comb begin
		nxt_calState = calState_ff;
		nxt_calCnt = calCnt_ff;
		nxt_stepCnt = stepTick ? '0 : stepCnt_ff + STEP_W'(1);
		nxt_calStart = 1'b0;
		case (calState_ff)
			adcr_pkg::CAL_IDLE: begin
				nxt_stepCnt = '0;
				if (calRequest) begin
					if (randPol_ff[`ADCR_BIT_CAL_EN]) begin
						nxt_calState = adcr_pkg::CAL_WAIT;
						nxt_calCnt = calDelay_ff;
					end else begin
						nxt_calStart = 1'b1;
					end
				end
			end
			adcr_pkg::CAL_WAIT: begin
				if (stepTick) begin
					if (calCnt_ff == 8'h00) begin
						nxt_calStart = 1'b1;
						nxt_calState = adcr_pkg::CAL_IDLE;
					end else begin
						nxt_calCnt = calCnt_ff - 8'h01;
					end
				end
			end
			default: nxt_calState = adcr_pkg::CAL_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			calState_ff <= adcr_pkg::CAL_IDLE;
			calCnt_ff <= 8'h00;
			stepCnt_ff <= '0;
			calStart_ff <= 1'b0;
		end else begin
			calState_ff <= nxt_calState;
			calCnt_ff <= nxt_calCnt;
			stepCnt_ff <= nxt_stepCnt;
			calStart_ff <= nxt_calStart;
		end
	end
	assign calStart = calStart_ff;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence calArmed;
		calState_ff == adcr_pkg::CAL_IDLE && calRequest && randPol_ff[`ADCR_BIT_CAL_EN];
	endsequence
	sequence calQuiet;
		!calStart_ff [*8];
	endsequence

	zero_codes_a: assert property (adcValid && boundary && actZero_ff
		|=> outValid_ff && outData_ff == '0)
		else $error("zeroed data code let data through");
	div_hold_a: assert property (adcValid && !boundary |=> !outValid_ff)
		else $error("word emitted before divider wrapped");
	div_emit_a: assert property (adcValid && boundary |=> outValid_ff)
		else $error("word missing at divider wrap");
	no_clock_a: assert property (actNoClk_ff |=> !dataClk_ff)
		else $error("data clock ran while disabled");
	indep_rate_a: assert property (adcValid && boundary && !indRate
		|=> actClkShift_ff == actDataShift_ff && !actNoClk_ff)
		else $error("clock rate field used while not independent");
	word_clock_a: assert property (outValid_ff
		&& $past(randPol_ff[`ADCR_BIT_WORD_CLK_INV])
		== $past(randPol_ff[`ADCR_BIT_WORD_CLK_INV], 2)
		|-> wordClockOut != $past(wordClockOut))
		else $error("word clock did not follow word");
	rand_data_a: assert property (adcValid && boundary && !actZero_ff
		&& !randPol_ff[`ADCR_BIT_RAND_EN] |=> outData_ff == $past(adcData))
		else $error("data altered with randomizer off");
	cal_nodelay_a: assert property (calState_ff == adcr_pkg::CAL_IDLE && calRequest
		&& !randPol_ff[`ADCR_BIT_CAL_EN] |=> calStart_ff)
		else $error("start delayed while counter disabled");
	cal_wait_a: assert property (calArmed |=> calQuiet)
		else $error("calibration started before delay");
	word_bound_a: assert property (!(adcValid && boundary)
		|=> $stable(actDataShift_ff) && $stable(actClkShift_ff))
		else $error("rate changed inside a word");
endmodule : adcr_output_rate_config

// ==== adcr_spi_host.sv ====
// Serial host model that writes and reads device registers
`timescale 1ns/1ps
module adcr_spi_host #(
	parameter int HALF = 8
) (
	input wire logic clock,
	output logic spiSclk,
	output logic spiCsN,
	output logic spiSdi,
	input wire logic spiSdo,
	input wire logic spiSdoOe
);
	logic [16:1] samp;
	initial begin
		spiSclk = 1'b0;
		spiCsN = 1'b1;
		spiSdi = 1'b0;
	end
	task automatic waitc(input int n);
		repeat (n) @(negedge clock);
	endtask : waitc
	// One frame: read flag, address, data, MSB first
	task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdat,
		input logic fallEdge, output logic [7:0] rdat);
		logic [15:0] frame;
		frame = {rd, addr, wdat};
		waitc(1);
		spiCsN = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spiSdi = frame[i];
			waitc(HALF);
			spiSclk = 1'b1;
			waitc(HALF - 1);
			// Only a driven line is trusted
			samp[16 - i] = spiSdoOe ? spiSdo : 1'bx;
			waitc(1);
			spiSclk = 1'b0;
		end
		waitc(HALF);
		spiCsN = 1'b1;
		// Released line shows the inverse
		spiSdi = ~spiSdi;
		for (int k = 0; k < 8; k++) begin
			rdat[7 - k] = samp[8 + k + int'(fallEdge)];
		end
		waitc(HALF);
	endtask : xfer
endmodule : adcr_spi_host

// ==== adcr_output_rate_config_tb_top.sv ====
// Self-checking bench for the output rate config block
`timescale 1ns/1ps
`include "adcr_consts.svh"
module adcr_output_rate_config_tb_top;
	localparam int DW = 16;
	localparam int STEP = 8;
	logic clock, rst, spiSclk, spiCsN, spiSdi, spiSdo, spiSdoOe;
	logic [DW-1:0] adcData, outData;
	logic adcValid, calRequest, outValid, dataClockOut, wordClockOut, calStart;
	int n_errors, cmp_count, cycles, settle, gapCnt, words, toggles, n;
	logic [31:0] rng;
	logic [7:0] genReg, rateReg, timReg, randReg, rd;
	logic wcPar, lastDataClk;
	logic [6:0] ofs [6] = '{7'h01, 7'h02, 7'h04, 7'h07, 7'h1E, 7'h10};
	logic [7:0] rv [6] = '{8'h00, 8'h0F, 8'h9F, 8'h62, 8'h80, 8'h00};
	logic [3:0] dCodes [8] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'hD, 4'hE, 4'hF};
	logic [7:0] calCtl [3] = '{8'h62, 8'h62, 8'h22};
	logic [7:0] calDly [3] = '{8'h80, 8'h00, 8'h03};
	int calExp [3] = '{129 * STEP + 1, STEP + 1, 1};

	adcr_output_rate_config #(.DATA_W(DW), .CAL_STEP_CYC(STEP)) adcr_output_rate_config_inst (
		.clock(clock), .rst(rst), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiSdi(spiSdi),
		.spiSdo(spiSdo), .spiSdoOe(spiSdoOe), .adcData(adcData), .adcValid(adcValid),
		.calRequest(calRequest), .outData(outData), .outValid(outValid),
		.dataClockOut(dataClockOut), .wordClockOut(wordClockOut), .calStart(calStart));
	adcr_spi_host adcr_spi_host_inst (.clock(clock), .spiSclk(spiSclk), .spiCsN(spiCsN),
		.spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOe(spiSdoOe));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic int exp_gap(input logic [3:0] c);
		if (c >= 4'h1 && c <= 4'h8) return 1 << (c + 1);
		return (c == 4'h9) ? 512 : 1;
	endfunction : exp_gap
	function automatic logic [DW-1:0] exp_word(input logic [DW-1:0] d);
		if (rateReg[7:4] >= 4'hD) return '0;
		if (randReg[0]) return {d[DW-1:1] ^ {(DW-1){d[0]}}, d[0]};
		return d;
	endfunction : exp_word

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test

	// words skipped across a rate change
	task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
		settle = 1000000;
		adcr_spi_host_inst.xfer(1'b0, a, d, timReg[7], rd);
		case (a)
			`ADCR_OFS_GEN_CTRL: genReg = {7'h00, d[0]};
			`ADCR_OFS_RATE: rateReg = d;
			`ADCR_OFS_TIMING: timReg = d;
			`ADCR_OFS_RANDPOL: randReg = d;
			default: ;
		endcase
		settle = 2;
		repeat (8) @(negedge clock);
	endtask : reg_wr
	task automatic reg_rd(input logic [6:0] a, input logic [7:0] exp);
		adcr_spi_host_inst.xfer(1'b1, a, 8'h00, timReg[7], rd);
		check(32'(rd), 32'(exp));
		repeat (8) @(negedge clock);
	endtask : reg_rd
	task automatic wait_words(input int w, input int lim);
		words = 0;
		for (int i = 0; i < lim && words < w + 2; i++) @(negedge clock);
		check(32'(words >= w + 2), 32'h1);
	endtask : wait_words
	task automatic clk_window(input logic [7:0] rate, input logic expRun);
		reg_wr(`ADCR_OFS_RATE, rate);
		toggles = 0;
		repeat (64) @(negedge clock);
		check(32'(toggles > 0), 32'(expRun));
	endtask : clk_window

	// Output monitor, then random converter words
	always @(negedge clock) begin
		if (!rst) begin
			if (adcValid) gapCnt++;
			if (lastDataClk !== dataClockOut) toggles++;
			lastDataClk = dataClockOut;
			if (outValid === 1'b1) begin
				wcPar = ~wcPar;
				words++;
				if (settle > 0) settle--;
				else begin
					check(32'(outData), 32'(exp_word(adcData)));
					if (rateReg[7:4] < 4'hD) check(gapCnt, exp_gap(rateReg[7:4]));
					check(32'(wordClockOut), 32'(wcPar ^ randReg[7]));
				end
				gapCnt = 0;
			end
			rng = xs(rng);
			adcData = rng[DW-1:0];
			adcValid = rng[20] | rng[21];
		end
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			$display("timeout after %0d cycles", cycles);
			finish_test();
		end
	end

	initial begin
		rst = 1'b1;
		adcData = '0;
		adcValid = 1'b0;
		calRequest = 1'b0;
		settle = 2;
		rng = 32'h0000E2BF;
		wcPar = 1'b0;
		lastDataClk = 1'b0;
		genReg = `ADCR_RST_GEN_CTRL;
		rateReg = `ADCR_RST_RATE;
		timReg = `ADCR_RST_TIMING;
		randReg = `ADCR_RST_RANDPOL;
		repeat (16) @(negedge clock);
		rst = 1'b0;
		repeat (6) @(negedge clock);
		foreach (ofs[i]) reg_rd(ofs[i], rv[i]);
		$display("test reset values done");
		// factory bits kept, launch edge moved
		reg_wr(`ADCR_OFS_TIMING, 8'h1F);
		reg_rd(`ADCR_OFS_TIMING, 8'h1F);
		reg_rd(`ADCR_OFS_RANDPOL, 8'h62);
		reg_wr(`ADCR_OFS_TIMING, 8'h9F);
		reg_rd(`ADCR_OFS_TIMING, 8'h9F);
		$display("test serial edge done");
		foreach (dCodes[i]) begin
			reg_wr(`ADCR_OFS_RATE, {dCodes[i], 4'hF});
			wait_words(4, 7000);
		end
		reg_wr(`ADCR_OFS_RANDPOL, 8'hE3);
		reg_wr(`ADCR_OFS_RATE, 8'h2F);
		wait_words(6, 2000);
		reg_wr(`ADCR_OFS_RATE, 8'h0F);
		wait_words(20, 500);
		$display("test formatter done");
		reg_wr(`ADCR_OFS_GEN_CTRL, 8'h01);
		for (int c = 10; c <= 14; c++) clk_window({4'h0, 4'(c)}, 1'b0);
		clk_window(8'h0F, 1'b1);
		// Clock toggling on every fourth word, an eighth of the word rate
		clk_window(8'h01, 1'b1);
		check(32'(toggles <= 17), 32'h1);
		reg_wr(`ADCR_OFS_GEN_CTRL, 8'h00);
		clk_window(8'h0E, 1'b1);
		$display("test data clock done");
		foreach (calCtl[i]) begin
			reg_wr(`ADCR_OFS_RANDPOL, calCtl[i]);
			reg_wr(`ADCR_OFS_CAL_DELAY, calDly[i]);
			calRequest = 1'b1;
			@(negedge clock);
			for (n = 1; n < 3000 && calStart !== 1'b1; n++) begin
				calRequest = (n == 4);
				@(negedge clock);
			end
			calRequest = 1'b0;
			check(32'(n >= calExp[i] - 1 && n <= calExp[i] + 1), 32'h1);
			repeat (4) @(negedge clock);
		end
		$display("test calibration delay done");
		finish_test();
	end
endmodule : adcr_output_rate_config_tb_top
